// >>> hw/csdc_clk_unit.sv
// clock source selection, division, clock export and channel sending end
`timescale 1ns/100ps
`include "csdc_params.svh"

// Behaviour
// - all registers run on the one clock
// - cross-domain values pass only via channel
// - pin clock usable direct or divided
// - expression bit usable direct or divided
// - on-chip generator usable direct or divided
// - generator offers exactly five nominal settings
// - generator users tolerate minus half, plus quarter
// - current clock reference is post-division clock
// - post-division clock driven to external interface
// - undivided pin clock readable as input bit
// - channel has one fixed sender and receiver
// - transfer lossless, sender stalls only while both buffer entries are full
// - completion detected only through the handshake
module csdc_clk_unit #(
  parameter int DIV_FACTOR = `CSDC_DIV_FACTOR_DEF,
  parameter int GEN_490HZ_HALF = `CSDC_CLK_SYS_HZ / (2 * `CSDC_GEN_490HZ_HZ),
  parameter int GEN_15HZ_HALF = `CSDC_CLK_SYS_HZ / (2 * `CSDC_GEN_15HZ_HZ)
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] src_sel,
  input wire logic [2:0] gen_sel,
  input wire logic div_en,
  input wire logic pin_clk,
  input wire logic expr_clk,
  output logic cur_clk,
  output logic ext_clk,
  output logic pin_clk_raw,
  output logic gen_clk,
  input wire logic tx_valid,
  input wire logic [`CSDC_WORD_W-1:0] tx_data,
  output logic tx_ready,
  csdc_if.tx ch
);

  localparam logic [`CSDC_CNT_W-1:0] DIV_N = DIV_FACTOR[`CSDC_CNT_W-1:0];
  localparam logic [`CSDC_CNT_W-1:0] DIV_HIGH = DIV_N >> 1;

  // half period of each generator setting in system cycles, rounded up for the three fastest (490 Hz and 15 Hz come from parameters), never below one
  function automatic logic [`CSDC_CNT_W-1:0] gen_half(input logic [2:0] sel);
    int h;
    case (sel)
      csdc_pkg::CSDC_GEN_8MHZ: h = (`CSDC_CLK_SYS_HZ + 2 * `CSDC_GEN_8MHZ_HZ - 1) / (2 * `CSDC_GEN_8MHZ_HZ);
      csdc_pkg::CSDC_GEN_500KHZ: h = (`CSDC_CLK_SYS_HZ + 2 * `CSDC_GEN_500KHZ_HZ - 1) / (2 * `CSDC_GEN_500KHZ_HZ);
      csdc_pkg::CSDC_GEN_16KHZ: h = (`CSDC_CLK_SYS_HZ + 2 * `CSDC_GEN_16KHZ_HZ - 1) / (2 * `CSDC_GEN_16KHZ_HZ);
      csdc_pkg::CSDC_GEN_490HZ: h = GEN_490HZ_HALF;
      csdc_pkg::CSDC_GEN_15HZ: h = GEN_15HZ_HALF;
      default: h = GEN_15HZ_HALF;
    endcase
    if (h < 1) begin
      h = 1;
    end
    return h[`CSDC_CNT_W-1:0];
  endfunction

  logic pin_s1_r;
  logic pin_s2_r;
  logic expr_s1_r;
  logic expr_s2_r;
  logic [`CSDC_CNT_W-1:0] gen_cnt_r;
  logic gen_clk_r;
  logic src_lvl;
  logic src_prev_r;
  logic src_rise;
  logic [`CSDC_CNT_W-1:0] div_cnt_r;
  logic [`CSDC_CNT_W-1:0] div_cnt_nxt;
  logic cur_clk_r;
  logic ext_clk_r;
  logic [2:0] gen_sel_r;

  // pin and expression clocks come from outside this domain: two flops each
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      expr_s1_r <= 1'b0;
      expr_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_clk;
      pin_s2_r <= pin_s1_r;
      expr_s1_r <= expr_clk;
      expr_s2_r <= expr_s1_r;
    end
  end

  // an out-of-range setting falls back to the slowest one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gen_sel_r <= csdc_pkg::CSDC_GEN_15HZ;
    end else if (gen_sel <= csdc_pkg::CSDC_GEN_8MHZ) begin
      gen_sel_r <= gen_sel;
    end else begin
      gen_sel_r <= csdc_pkg::CSDC_GEN_15HZ;
    end
  end

  // generator model; rounding the half period up keeps the three fastest rates at or below
  // nominal, inside the tolerance band, so its users must not count on the rate
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gen_cnt_r <= {`CSDC_CNT_W{1'b0}};
      gen_clk_r <= 1'b0;
    end else if (gen_cnt_r + 1'b1 >= gen_half(gen_sel_r)) begin
      gen_cnt_r <= {`CSDC_CNT_W{1'b0}};
      gen_clk_r <= !gen_clk_r;
    end else begin
      gen_cnt_r <= gen_cnt_r + 1'b1;
    end
  end

  always_comb begin
    case (src_sel)
      csdc_pkg::CSDC_SRC_PIN: src_lvl = pin_s2_r;
      csdc_pkg::CSDC_SRC_EXPR: src_lvl = expr_s2_r;
      csdc_pkg::CSDC_SRC_GEN: src_lvl = gen_clk_r;
      default: src_lvl = gen_clk_r;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_lvl;
    end
  end

  assign src_rise = src_lvl && !src_prev_r;

  // counts every source rising edge from reset and wraps at the factor
  always_comb begin
    div_cnt_nxt = div_cnt_r;
    if (src_rise) begin
      if (div_cnt_r + 1'b1 >= DIV_N) begin
        div_cnt_nxt = {`CSDC_CNT_W{1'b0}};
      end else begin
        div_cnt_nxt = div_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt_r <= {`CSDC_CNT_W{1'b0}};
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  // with division, high for the first N/2 (rounded down, at least one) of the N source periods
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_clk_r <= 1'b0;
    end else if (!div_en || DIV_N <= 1) begin
      cur_clk_r <= src_lvl;
    end else if (src_rise) begin
      cur_clk_r <= (div_cnt_nxt < ((DIV_HIGH == 0) ? 1 : DIV_HIGH));
    end else if (!src_lvl && DIV_N == 2) begin
      cur_clk_r <= cur_clk_r;
    end
  end

  // exported copy follows the post-division clock one cycle behind
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_clk_r <= 1'b0;
    end else begin
      ext_clk_r <= cur_clk_r;
    end
  end

  assign cur_clk = cur_clk_r;
  assign ext_clk = ext_clk_r;
  assign pin_clk_raw = pin_s2_r;
  assign gen_clk = gen_clk_r;

  // two-entry sending buffer
  logic [`CSDC_WORD_W-1:0] mem_r [`CSDC_BUF_DEPTH];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic valid_r;
  logic ready_r;
  logic push;
  logic pop;

  assign push = tx_valid && ready_r;
  assign pop = valid_r && ch.ready;

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= csdc_pkg::CSDC_BUF_EMPTY;
      valid_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      valid_r <= (cnt_nxt != csdc_pkg::CSDC_BUF_EMPTY);
      // sender stalls while both entries hold words not yet taken
      ready_r <= (cnt_nxt != csdc_pkg::CSDC_BUF_FULL);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= !wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= !rd_ptr_r;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_r[0] <= {`CSDC_WORD_W{1'b0}};
      mem_r[1] <= {`CSDC_WORD_W{1'b0}};
    end else if (push) begin
      mem_r[wr_ptr_r] <= tx_data;
    end
  end

  // only this end drives valid and data, so the direction cannot turn
  always_comb begin
    ch.valid = valid_r;
    ch.data = mem_r[rd_ptr_r];
  end

  assign tx_ready = ready_r;

endmodule

// >>> shared/csdc_params.svh
// constants for the clock source unit and the cross-domain channel
`ifndef CSDC_PARAMS_SVH
`define CSDC_PARAMS_SVH

// system clock rate, in hertz
`define CSDC_CLK_SYS_HZ 25000000

// nominal on-chip generator settings, in hertz
`define CSDC_GEN_8MHZ_HZ 8000000
`define CSDC_GEN_500KHZ_HZ 500000
`define CSDC_GEN_16KHZ_HZ 16000
`define CSDC_GEN_490HZ_HZ 490
`define CSDC_GEN_15HZ_HZ 15

// generator tolerance against nominal, in percent
`define CSDC_GEN_TOL_LOW_PCT 50
`define CSDC_GEN_TOL_HIGH_PCT 25

// channel word width and buffer depth
`define CSDC_WORD_W 8
`define CSDC_BUF_DEPTH 2

// default divide factor
`define CSDC_DIV_FACTOR_DEF 3

// width of cycle and divide counters
`define CSDC_CNT_W 32

`endif

// >>> shared/csdc_pkg.sv
// types for the clock source unit and the cross-domain channel
package csdc_pkg;

  // where the unit clock comes from
  typedef enum logic [1:0] {
    CSDC_SRC_GEN,
    CSDC_SRC_EXPR,
    CSDC_SRC_PIN
  } csdc_src_t;

  // on-chip generator frequency selection
  typedef enum logic [2:0] {
    CSDC_GEN_15HZ,
    CSDC_GEN_490HZ,
    CSDC_GEN_16KHZ,
    CSDC_GEN_500KHZ,
    CSDC_GEN_8MHZ
  } csdc_gen_t;

  // sender buffer occupancy
  typedef enum logic [1:0] {
    CSDC_BUF_EMPTY,
    CSDC_BUF_ONE,
    CSDC_BUF_FULL
  } csdc_buf_t;

endpackage

// >>> shared/csdc_if.sv
// one-way point-to-point channel between the sending and receiving ends
`timescale 1ns/100ps
`include "csdc_params.svh"

interface csdc_if;
  logic valid;
  logic ready;
  logic [`CSDC_WORD_W-1:0] data;

  // direction is fixed by the modports: sender drives valid and data only
  modport tx (
    output valid,
    output data,
    input ready
  );

  modport rx (
    input valid,
    input data,
    output ready
  );
endinterface

// >>> hw/csdc_rx_end.sv
// receiving end of the cross-domain channel
`timescale 1ns/100ps
`include "csdc_params.svh"

module csdc_rx_end (
  input wire logic clk_sys,
  input wire logic rst,
  csdc_if.rx ch,
  output logic rx_valid,
  output logic [`CSDC_WORD_W-1:0] rx_data,
  input wire logic rx_ready
);

  logic full_r;
  logic [`CSDC_WORD_W-1:0] data_r;
  logic take;
  logic drain;

  // a word is taken only on the handshake, never after a fixed delay
  assign take = ch.valid && !full_r;
  assign drain = full_r && rx_ready;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      full_r <= 1'b0;
    end else if (take) begin
      full_r <= 1'b1;
    end else if (drain) begin
      full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_r <= {`CSDC_WORD_W{1'b0}};
    end else if (take) begin
      data_r <= ch.data;
    end
  end

  // ready is the registered complement of full, so one word every two cycles at most
  always_comb begin
    ch.ready = !full_r;
  end

  assign rx_valid = full_r;
  assign rx_data = data_r;

endmodule

// >>> verif/csdc_chk.sv
// assertions on the channel between the sending and receiving ends
`timescale 1ns/100ps
`include "csdc_params.svh"
module csdc_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic valid,
  input wire logic ready,
  input wire logic [`CSDC_WORD_W-1:0] data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a stalled word must stay offered, unchanged, until it is taken
  valid_hold_a: assert property (valid && !ready |=> valid) else $error("word withdrawn");
  data_hold_a: assert property (valid && !ready |=> $stable(data)) else $error("data moved");
  take_gap_a: assert property (valid && ready |=> !ready) else $error("ready held after take");
  stall_bound_a: assert property (valid |-> ##[0:60] ready) else $error("word never taken");
  reset_idle_a: assert property (disable iff (1'b0) rst |=> !valid) else $error("valid in reset");
  reset_ready_a: assert property (disable iff (1'b0) rst |=> ready) else $error("ready low in reset");
  cover property (valid && ready);
  cover property (valid && !ready);
  cover property ($fell(rst));
endmodule

// >>> verif/csdc_tb.sv
// self-checking bench for the clock unit and both channel ends
`timescale 1ns/100ps
`include "csdc_params.svh"
module csdc_tb;
  logic clk_sys = 0, rst = 1, div_en = 0, pin_clk = 0, expr_clk = 0;
  logic tx_valid = 0, rx_ready = 0, stall = 0, cur_d = 0, ck_ext = 0;
  logic [1:0] use_raw = 2'h0;
  logic [1:0] src_sel = 2'h0;
  logic [2:0] gen_sel = 3'h4;
  logic [`CSDC_WORD_W-1:0] tx_data = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic cur_clk, ext_clk, pin_clk_raw, gen_clk, tx_ready, rx_valid;
  logic [`CSDC_WORD_W-1:0] rx_data;
  logic [`CSDC_WORD_W-1:0] q[$];
  int fails = 0;
  int total_checks = 0;
  int i, per, rate;
  // src, gen setting, divide, probe (1 raw pin, 2 generator), expected period in cycles
  int cfg[13][5] = '{'{0, 4, 0, 0, 4}, '{0, 4, 1, 0, 12}, '{0, 3, 0, 0, 50}, '{0, 1, 0, 0, 8},
    '{0, 0, 0, 0, 12}, '{0, 7, 0, 0, 12}, '{3, 4, 0, 0, 4}, '{1, 4, 0, 0, 4}, '{1, 4, 1, 0, 12},
    '{2, 4, 0, 0, 8}, '{2, 4, 1, 0, 24}, '{2, 4, 1, 1, 8}, '{0, 4, 0, 2, 4}};
  wire logic probe = (use_raw == 2'h2) ? gen_clk : (use_raw[0] ? pin_clk_raw : cur_clk);
  csdc_if ch();
  csdc_clk_unit #(.DIV_FACTOR(3), .GEN_490HZ_HALF(4), .GEN_15HZ_HALF(6)) u_csdc_clk_unit (
    .clk_sys(clk_sys), .rst(rst), .src_sel(src_sel), .gen_sel(gen_sel), .div_en(div_en),
    .pin_clk(pin_clk), .expr_clk(expr_clk), .cur_clk(cur_clk), .ext_clk(ext_clk),
    .pin_clk_raw(pin_clk_raw), .gen_clk(gen_clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .ch(ch.tx));
  csdc_rx_end u_csdc_rx_end (.clk_sys(clk_sys), .rst(rst), .ch(ch.rx), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready));
  csdc_chk u_csdc_chk (.clk_sys(clk_sys), .rst(rst), .valid(ch.valid), .ready(ch.ready), .data(ch.data));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task results;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // holds the word until tx_ready is seen at an edge, then notes it
  task send(input logic [`CSDC_WORD_W-1:0] w);
    int n;
    n = 0;
    tx_valid <= 1;
    tx_data <= w;
    do @(posedge clk_sys); while (tx_ready !== 1'b1 && ++n < 100);
    // a word that is never taken is a failure, not a silent skip
    if (n >= 100) fails++;
    q.push_back(w);
  endtask

  // time between two rises of the probed clock, after settling
  task measure(input int e);
    int n, t;
    logic p;
    t = -1;
    p = 1;
    repeat (60) @(posedge clk_sys);
    for (n = 0; n < 400; n++) begin
      @(posedge clk_sys);
      if (probe === 1'b1 && p === 1'b0) begin
        if (t >= 0) break;
        t = n;
      end
      p = probe;
    end
    per = n - t;
    check("period", per, e);
  endtask

  initial forever #20 clk_sys = ~clk_sys;

  // sources are toggled off the system clock: pin period 8, expression period 4
  always @(posedge clk_sys) begin
    cnt <= cnt + 8'h01;
    pin_clk <= cnt[2];
    expr_clk <= cnt[1];
    cur_d <= cur_clk;
    rx_ready <= !stall && $urandom_range(1);
    if (ck_ext) check("ext_clk", ext_clk, cur_d);
    if (rx_valid === 1'b1 && rx_ready === 1'b1) check("word", rx_data, q.size() ? q.pop_front() : 'x);
  end

  initial begin
    void'($urandom(23134));
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    repeat (2) @(posedge clk_sys);
    for (i = 0; i < 150; i++) send(8'($urandom));
    tx_valid <= 0;
    repeat (20) @(posedge clk_sys);
    // receiver stalls: one word held at the far end, two in the buffer
    stall <= 1;
    repeat (3) send(8'($urandom));
    tx_valid <= 0;
    repeat (4) @(posedge clk_sys);
    check("tx_ready", tx_ready, 0);
    stall <= 0;
    repeat (30) @(posedge clk_sys);
    check("left", q.size(), 0);
    ck_ext <= 1;
    for (i = 0; i < 13; i++) begin
      src_sel <= 2'(cfg[i][0]);
      gen_sel <= 3'(cfg[i][1]);
      div_en <= 1'(cfg[i][2]);
      use_raw <= 2'(cfg[i][3]);
      measure(cfg[i][4]);
      // the fastest generator setting must stay inside the band its users accept
      if (cfg[i][3] == 2) begin
        rate = `CSDC_CLK_SYS_HZ / per;
        check("gen_rate_low", rate >= `CSDC_GEN_8MHZ_HZ / 100 * (100 - `CSDC_GEN_TOL_LOW_PCT), 1);
        check("gen_rate_high", rate <= `CSDC_GEN_8MHZ_HZ / 100 * (100 + `CSDC_GEN_TOL_HIGH_PCT), 1);
      end
    end
    results();
  end

  // the run needs about 1500 cycles
  initial begin
    #800000;
    fails++;
    results();
  end
endmodule
